// File: shared/acrc_pkg.sv
// What this block does
// (R01) The conversion clock comes from the divided system clock or from the RC oscillator.
// (R02) The divided clock is the system clock over 2*(n+1), n being the 6-bit divide field.
// (R03) One full 10-bit conversion lasts 11.5 bit conversion periods.
// (R04) Control runs on the selected conversion clock, so RC mode may delay control updates.
// (R05) Outside RC mode the conversion clock follows any change of the system clock.
// (R06) Negative reference bit 4 picks the external reference pin at 1, analog ground at 0.
// (R07) Positive reference bits 1-0 pick: 11 reference buffer, 10 pin, 00 supply, 01 reserved.
// (R08) Unimplemented bits of the divider and reference registers read as zero, ignore writes.
// (R09) Exactly one input, the one the channel register names, reaches the sample-and-hold.
// (R10) Software waits a settling delay after a channel change before the next conversion.
// (R11) Software should pass through a ground channel when moving to a lower-voltage one.
// (R12) Clock and reference settings change only between conversions.
package acrc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int DIV_W = 6;
  localparam int CHAN_W = 6;
  localparam int RES_W = 10;
  localparam int PREF_W = 2;
  localparam int CNT_W = 5;
  localparam int BIT_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CLK = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_REF = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CHAN = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;
  localparam int NREF_BIT = 4;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RES_LSB = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 6'h00;
  localparam logic [PREF_W-1:0] PREF_RESET = 2'h0;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam logic [RES_W-1:0] SAR_FIRST = 10'h200;
  localparam logic [BIT_W-1:0] SAR_MSB = 4'h9;
  // Counted in half bit periods: 11.5 periods is 23 halves, sampling takes 3.
  localparam logic [CNT_W-1:0] HALF_CONV = 5'd23;
  localparam logic [CNT_W-1:0] HALF_SAMPLE = 5'd3;

  typedef struct packed {
    logic src;
    logic [DIV_W-1:0] div;
    logic nref;
    logic [PREF_W-1:0] pref;
  } acrc_cfg_t;

  typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT} acrc_phase_t;
endpackage

// File: src/acrc_ctrl.sv
`timescale 1ns/1ps
module acrc_ctrl #(
  parameter int RC_HALF_CYCLES = 25
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [acrc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [acrc_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [acrc_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CMP_IN,
  output logic [acrc_pkg::RES_W-1:0] SAR_TRIAL,
  output logic SAMPLE_HOLD,
  output logic [acrc_pkg::PREF_W-1:0] POS_REF_SEL,
  output logic NEG_REF_SEL,
  output logic [acrc_pkg::CHAN_W-1:0] CHANNEL_SEL,
  output logic CONV_CLK_SRC,
  output logic CONV_BUSY
);
  import acrc_pkg::*;

  // Register group state.
  logic [DIV_W-1:0] clk_div;
  logic nref_reg;
  logic [PREF_W-1:0] pref_reg;
  logic src_reg;
  logic go;
  logic done;
  logic [CHAN_W-1:0] chan;
  logic wait_q;
  logic [DATA_W-1:0] rdata;
  logic [DIV_W-1:0] next_clk_div;
  logic next_nref_reg;
  logic [PREF_W-1:0] next_pref_reg;
  logic next_src_reg;
  logic next_go;
  logic next_done;
  logic [CHAN_W-1:0] next_chan;
  logic next_wait_q;
  logic [DATA_W-1:0] next_rdata;

  // Tick group state.
  logic [DIV_W-1:0] div_cnt;
  logic [7:0] rc_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [7:0] next_rc_cnt;

  // Conversion group state.
  acrc_cfg_t cfg;
  acrc_cfg_t next_cfg;
  acrc_phase_t phase;
  acrc_phase_t next_phase;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [BIT_W-1:0] bitpos;
  logic [BIT_W-1:0] next_bitpos;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] next_trial;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] next_result;

  logic req;
  logic acc_wr;
  logic div_tick;
  logic rc_tick;
  logic half_tick;
  logic start;
  logic finish;
  logic [RES_W-1:0] decided;

  localparam logic [7:0] RC_LAST = 8'(RC_HALF_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: every access waits one cycle, then completes.

  assign req = AVS_READ | AVS_WRITE;
  assign acc_wr = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];

  always_comb begin
    next_wait_q = ~(req & wait_q);
    next_rdata = rdata;
    next_clk_div = clk_div;
    next_nref_reg = nref_reg;
    next_pref_reg = pref_reg;
    next_src_reg = src_reg;
    next_chan = chan;
    next_done = done;
    next_go = go & ~start;
    if (AVS_READ && wait_q) begin
      next_rdata = '0;
      unique case (AVS_ADDRESS)
        OFS_CLK: next_rdata[DIV_W-1:0] = clk_div; // see (R08)
        OFS_REF: begin
          next_rdata[NREF_BIT] = nref_reg; // see (R08)
          next_rdata[PREF_W-1:0] = pref_reg;
        end
        OFS_CTRL: begin
          next_rdata[CTRL_SRC_BIT] = src_reg;
          next_rdata[CTRL_GO_BIT] = go | CONV_BUSY;
        end
        OFS_CHAN: next_rdata[CHAN_W-1:0] = chan;
        OFS_STAT: begin
          next_rdata[STAT_BUSY_BIT] = CONV_BUSY;
          next_rdata[STAT_DONE_BIT] = done;
          next_rdata[STAT_RES_LSB +: RES_W] = result;
        end
        default: next_rdata = '0;
      endcase
    end
    if (acc_wr) begin
      unique case (AVS_ADDRESS)
        OFS_CLK: next_clk_div = AVS_WRITEDATA[DIV_W-1:0]; // see (R08)
        OFS_REF: begin
          next_nref_reg = AVS_WRITEDATA[NREF_BIT];
          next_pref_reg = AVS_WRITEDATA[PREF_W-1:0];
        end
        OFS_CTRL: begin
          next_src_reg = AVS_WRITEDATA[CTRL_SRC_BIT];
          next_go = next_go | AVS_WRITEDATA[CTRL_GO_BIT];
        end
        OFS_CHAN: next_chan = AVS_WRITEDATA[CHAN_W-1:0];
        OFS_STAT: next_done = done & ~AVS_WRITEDATA[STAT_DONE_BIT];
        default: next_done = done;
      endcase
    end
    // A finishing conversion wins over a clear in the same cycle.
    if (finish) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      wait_q <= 1'b1;
      rdata <= '0;
      clk_div <= DIV_RESET;
      nref_reg <= 1'b0;
      pref_reg <= PREF_RESET;
      src_reg <= 1'b0;
      chan <= CHAN_RESET;
      done <= 1'b0;
      go <= 1'b0;
    end else begin
      wait_q <= next_wait_q;
      rdata <= next_rdata;
      clk_div <= next_clk_div;
      nref_reg <= next_nref_reg;
      pref_reg <= next_pref_reg;
      src_reg <= next_src_reg;
      chan <= next_chan;
      done <= next_done;
      go <= next_go;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata;
  assign CHANNEL_SEL = chan; // see (R09)

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion clock as half-period enables; the divider counts system clocks
  // directly, so its rate follows the system clock.

  assign div_tick = (div_cnt == cfg.div); // see (R02) (R05)
  assign rc_tick = (rc_cnt == RC_LAST);
  assign half_tick = cfg.src ? rc_tick : div_tick; // see (R01)

  always_comb begin
    next_div_cnt = div_tick ? '0 : div_cnt + 1'b1;
    next_rc_cnt = rc_tick ? '0 : rc_cnt + 1'b1;
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      div_cnt <= '0;
      rc_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      rc_cnt <= next_rc_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Successive approximation sequencer, advanced only on conversion clock ticks.

  assign start = half_tick && (phase == PH_IDLE) && go;
  assign finish = half_tick && (phase == PH_CONVERT) && (cnt + 1'b1 == HALF_CONV);

  always_comb begin
    decided = trial;
    decided[bitpos] = CMP_IN;
  end

  always_comb begin
    next_cfg = cfg;
    next_phase = phase;
    next_cnt = cnt;
    next_bitpos = bitpos;
    next_trial = trial;
    next_result = result;
    if (half_tick) begin
      unique case (phase)
        PH_IDLE: begin
          // Settings are taken on a tick of the running clock, never mid-conversion.
          next_cfg = '{src: src_reg, div: clk_div, nref: nref_reg,
                       pref: pref_reg}; // see (R04) (R12)
          if (go) begin
            next_phase = PH_SAMPLE;
            next_cnt = '0;
          end
        end
        PH_SAMPLE: begin
          next_cnt = cnt + 1'b1;
          if (cnt + 1'b1 == HALF_SAMPLE) begin
            next_phase = PH_CONVERT;
            next_trial = SAR_FIRST;
            next_bitpos = SAR_MSB;
          end
        end
        PH_CONVERT: begin
          next_cnt = cnt + 1'b1;
          if (!cnt[0]) begin
            next_trial = decided;
            if (bitpos != '0) begin
              next_trial[bitpos - 1'b1] = 1'b1;
              next_bitpos = bitpos - 1'b1;
            end
          end
          if (finish) begin
            next_phase = PH_IDLE; // see (R03)
            next_result = decided;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cfg <= '0;
      phase <= PH_IDLE;
      cnt <= '0;
      bitpos <= '0;
      trial <= RES_RESET;
      result <= RES_RESET;
      SAMPLE_HOLD <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else begin
      cfg <= next_cfg;
      phase <= next_phase;
      cnt <= next_cnt;
      bitpos <= next_bitpos;
      trial <= next_trial;
      result <= next_result;
      SAMPLE_HOLD <= (next_phase == PH_SAMPLE);
      CONV_BUSY <= (next_phase != PH_IDLE);
    end
  end

  assign SAR_TRIAL = trial;
  assign POS_REF_SEL = cfg.pref; // see (R07)
  assign NEG_REF_SEL = cfg.nref; // see (R06)
  assign CONV_CLK_SRC = cfg.src;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  logic [CNT_W-1:0] len;
  logic [7:0] gap;
  // Spacing checks skip the first tick after a source change, whose phase is arbitrary.
  logic prev_div;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      len <= '0;
      gap <= '0;
      prev_div <= 1'b0;
    end else begin
      len <= start ? 5'd1 : (half_tick && CONV_BUSY ? len + 1'b1 : len);
      gap <= half_tick ? 8'd1 : gap + 1'b1;
      prev_div <= half_tick ? !cfg.src : prev_div;
    end
  end

  property p_div_period;
    half_tick && !cfg.src && $past(half_tick && !cfg.src) |-> cfg.div == 6'h00;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider tick too early"); // see (R02)

  property p_div_gap;
    half_tick && !cfg.src && $stable(cfg) && prev_div |-> gap == 8'(cfg.div) + 8'd1;
  endproperty
  a_div_gap: assert property (p_div_gap) else $error("divider half period wrong"); // see (R02)

  property p_conv_len;
    finish |-> len == HALF_CONV;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // see (R03)

  property p_cfg_hold;
    CONV_BUSY && $past(CONV_BUSY) |-> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings moved mid-conversion"); // see (R12)

  property p_cfg_on_tick;
    $changed(cfg) |-> $past(half_tick) && !$past(CONV_BUSY);
  endproperty
  a_cfg_on_tick: assert property (p_cfg_on_tick) else $error("settings applied off tick"); // see (R04)

  property p_rc_tick;
    half_tick && cfg.src && $stable(cfg) && !prev_div |-> gap == 8'(RC_HALF_CYCLES);
  endproperty
  a_rc_tick: assert property (p_rc_tick) else $error("RC half period wrong"); // see (R01)

  property p_clk_unimpl;
    AVS_READ && !wait_q && AVS_ADDRESS == OFS_CLK |-> AVS_READDATA[DATA_W-1:DIV_W] == '0;
  endproperty
  a_clk_unimpl: assert property (p_clk_unimpl) else $error("divider high bits not zero"); // see (R08)

  property p_ref_unimpl;
    AVS_READ && !wait_q && AVS_ADDRESS == OFS_REF
      |-> AVS_READDATA[3:2] == 2'h0 && AVS_READDATA[DATA_W-1:5] == '0;
  endproperty
  a_ref_unimpl: assert property (p_ref_unimpl) else $error("reference pad bits not zero"); // see (R08)

  property p_chan_write;
    acc_wr && AVS_ADDRESS == OFS_CHAN |=> CHANNEL_SEL == $past(AVS_WRITEDATA[CHAN_W-1:0]);
  endproperty
  a_chan_write: assert property (p_chan_write) else $error("channel not routed"); // see (R09)

  property p_wait_pulse;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
endmodule

// File: testbench/tb_adc_clock_ref_channel_ctrl.sv
`timescale 1ns/1ps
module tb_adc_clock_ref_channel_ctrl;
  import acrc_pkg::*;
  logic MCLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CMP_IN;
  logic SAMPLE_HOLD, NEG_REF_SEL, CONV_CLK_SRC, CONV_BUSY;
  logic [ADDR_W-1:0] AVS_ADDRESS;
  logic [DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0] AVS_BYTEENABLE;
  logic [RES_W-1:0] SAR_TRIAL, level;
  logic [PREF_W-1:0] POS_REF_SEL;
  logic [CHAN_W-1:0] CHANNEL_SEL;
  int n_errors, checked;
  // The design does not decode channel codes; this ground code is arbitrary.
  localparam logic [CHAN_W-1:0] GND_CHAN = 6'h3b;
  localparam int SETTLE = 8;

  // Ideal comparator: the analog side answers the trial code at once.
  assign CMP_IN = (level >= SAR_TRIAL);

  acrc_ctrl #(.RC_HALF_CYCLES(2)) dut_u (.MCLK(MCLK), .RESET(RESET),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CMP_IN(CMP_IN),
    .SAR_TRIAL(SAR_TRIAL), .SAMPLE_HOLD(SAMPLE_HOLD), .POS_REF_SEL(POS_REF_SEL),
    .NEG_REF_SEL(NEG_REF_SEL), .CHANNEL_SEL(CHANNEL_SEL), .CONV_CLK_SRC(CONV_CLK_SRC),
    .CONV_BUSY(CONV_BUSY));

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low.
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge MCLK);
      n++;
      if (n > 100) begin
        n_errors++;
        print_verdict;
      end
    end
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge MCLK);
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(what, exp, rd);
  endtask

  task wait_for(input logic lvl, input logic src_wait);
    int n;
    n = 0;
    while ((src_wait ? CONV_CLK_SRC : CONV_BUSY) !== lvl) begin
      @(posedge MCLK);
      n++;
      if (n > 3000) begin
        n_errors++;
        print_verdict;
      end
    end
  endtask

  task t_regs;
    rdchk("clk reset", OFS_CLK, 32'h0);
    rdchk("ref reset", OFS_REF, 32'h0);
    rdchk("ctrl reset", OFS_CTRL, 32'h0);
    rdchk("chan reset", OFS_CHAN, 32'h0);
    rdchk("stat reset", OFS_STAT, 32'h0);
    wr(OFS_CLK, 32'hffffffff);
    rdchk("clk bits", OFS_CLK, 32'h3f);
    wr(OFS_REF, 32'hffffffff);
    rdchk("ref bits", OFS_REF, 32'h13);
    wr(OFS_CHAN, 32'h2a);
    chk("channel out", 32'h2a, {26'h0, CHANNEL_SEL});
    bus(1'b1, OFS_CHAN, 32'h15, 4'he);
    rdchk("chan no lane0", OFS_CHAN, 32'h2a);
    wr(5'h14, 32'hff);
    rdchk("unmapped", 5'h14, 32'h0);
    $display("test regs done");
  endtask

  task t_refs;
    wr(OFS_CLK, 32'h0);
    // The old divide field stays in force until its next half tick, up to 64 cycles away.
    repeat ((1 << DIV_W) + 2) @(posedge MCLK);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_REF, {27'h0, i[0], 2'h0, i[1:0]});
      repeat (4) @(posedge MCLK);
      chk("pos ref", i[1:0], {30'h0, POS_REF_SEL});
      chk("neg ref", i[0], {31'h0, NEG_REF_SEL});
    end
    $display("test refs done");
  endtask

  // Runs one conversion and times it against 23 half ticks of the chosen clock.
  task conv(input logic [5:0] div, input logic src, input logic [9:0] lvl);
    int cnt;
    int sh;
    logic seen;
    level <= lvl;
    sh = 1;
    seen = 1'b0;
    wr(OFS_CLK, {26'h0, div});
    wr(OFS_CTRL, {31'h0, src});
    wait_for(src, 1'b1);
    wr(OFS_CHAN, {26'h0, GND_CHAN});
    wr(OFS_CHAN, {26'h0, lvl[5:0]});
    repeat (SETTLE) @(posedge MCLK);
    chk("channel", {26'h0, lvl[5:0]}, {26'h0, CHANNEL_SEL});
    wr(OFS_CTRL, {30'h0, 1'b1, src});
    wait_for(1'b1, 1'b0);
    chk("sampling", 32'h1, {31'h0, SAMPLE_HOLD});
    cnt = 0;
    while (CONV_BUSY === 1'b1 && cnt < 3000) begin
      @(posedge MCLK);
      cnt++;
      if (SAMPLE_HOLD === 1'b1) begin
        sh++;
      end else if (!seen) begin
        seen = 1'b1;
        chk("first trial", 32'h200, {22'h0, SAR_TRIAL});
      end
    end
    chk("conv cycles", src ? 32'd46 : 23 * (div + 1), cnt);
    chk("sample cycles", src ? 32'd6 : HALF_SAMPLE * (div + 1), sh);
    rdchk("status", OFS_STAT, {6'h0, lvl, 14'h0, 2'h2});
    wr(OFS_STAT, 32'h2);
    rdchk("done clear", OFS_STAT, {6'h0, lvl, 16'h0});
    $display("test conv div %0d src %0d done", div, src);
  endtask

  // A reference change written mid-conversion must wait for idle.
  task t_hold;
    wr(OFS_REF, 32'h0);
    wr(OFS_CLK, 32'h7);
    wr(OFS_CTRL, 32'h2);
    wait_for(1'b1, 1'b0);
    wr(OFS_REF, 32'h13);
    chk("pos held", 32'h0, {30'h0, POS_REF_SEL});
    chk("neg held", 32'h0, {31'h0, NEG_REF_SEL});
    wait_for(1'b0, 1'b0);
    repeat (20) @(posedge MCLK);
    chk("pos applied", 32'h3, {30'h0, POS_REF_SEL});
    chk("neg applied", 32'h1, {31'h0, NEG_REF_SEL});
    $display("test hold done");
  endtask

  initial begin
    n_errors = 0;
    checked = 0;
    RESET = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = '0;
    AVS_WRITEDATA = '0;
    AVS_BYTEENABLE = 4'hf;
    level = 10'h0;
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    t_regs;
    t_refs;
    conv(6'h00, 1'b0, 10'h2a5);
    conv(6'h02, 1'b0, 10'h3ff);
    conv(6'h3e, 1'b0, 10'h000);
    conv(6'h00, 1'b1, 10'h0aa);
    conv(6'h01, 1'b0, 10'h155);
    t_hold;
    print_verdict;
  end
endmodule
